// ### rtl/or_ret_rot_exec.sv
// Purpose: Executes OR, subroutine/interrupt exits and left rotations
// Assumes: Caller supplies opcode, immediate, memory byte and stack top
//          int_pending_i and gie_clear_i come from logic on core_clk_i
// Notes:   One instruction per cycle; results appear the next edge
//          Stack storage and its pointer live outside; stack_pop_o asks for the pop
//          A request pending at an interrupt exit is handed back on int_take_o; vectoring is external
//          Only bit 0 of the interrupt control register is implemented
//          Memory write address and data hold after the strobe drops
//          Program counter wraps silently at the top of program space
module or_ret_rot_exec
  import or_ret_rot_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              exec_valid_i,
  input  wire logic [OP_W-1:0]   opcode_i,
  input  wire logic [DATA_W-1:0] imm_i,
  input  wire logic [ADDR_W-1:0] mem_addr_i,
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  input  wire logic [PC_W-1:0]   stack_top_i,
  input  wire logic              int_pending_i,
  input  wire logic              gie_clear_i,
  output logic [DATA_W-1:0]      acc_o,
  output logic                   zero_flag_o,
  output logic [PC_W-1:0]        pc_o,
  output logic [DATA_W-1:0]      interrupt_control_register_o,
  output logic                   mem_we_o,
  output logic [ADDR_W-1:0]      mem_waddr_o,
  output logic [DATA_W-1:0]      mem_wdata_o,
  output logic                   stack_pop_o,
  output logic                   int_take_o
);

  // Whole state in one register; every output is one of its fields
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic              zero_flag;
    logic [PC_W-1:0]   pc;
    logic [DATA_W-1:0] interrupt_control_register;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata;
    logic              stack_pop;
    logic              int_take;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == ZERO_BYTE);
  endfunction : is_zero

  // Exits of all three kinds share the stack pop
  function automatic logic pops_stack(input op_t op);
    pops_stack = (op == OP_SUB_EXIT) || (op == OP_SUB_EXIT_LIT) || (op == OP_INT_EXIT);
  endfunction : pops_stack

  function automatic logic writes_mem(input op_t op);
    writes_mem = (op == OP_OR_MEM) || (op == OP_ROT_MEM);
  endfunction : writes_mem

  // Rotations deliberately leave the zero flag alone
  function automatic logic updates_zero(input op_t op);
    updates_zero = (op == OP_OR_IMM) || (op == OP_OR_MEM);
  endfunction : updates_zero

  op_t               op;
  logic [DATA_W-1:0] or_imm;
  logic [DATA_W-1:0] or_mem;
  logic [DATA_W-1:0] or_result;
  logic [PC_W-1:0]   pc_inc;
  wire  [DATA_W-1:0] rot_byte;

  assign op        = op_t'(opcode_i);
  assign or_imm    = cur.acc | imm_i;
  assign or_mem    = cur.acc | mem_rdata_i;
  assign or_result = (op == OP_OR_IMM) ? or_imm : or_mem;
  // Wraps at the top of program space; no overflow trap
  assign pc_inc    = PC_W'(cur.pc + PC_STEP);

  // One wire per bit; the top bit wraps round to bit 0
  for (genvar g = 0; g < DATA_W; g++)
  begin : g_rot
    if (g == MSB_BIT)
    begin : g_wrap
      assign rot_byte[0] = mem_rdata_i[g];
    end
    else
    begin : g_shift
      assign rot_byte[g + 1] = mem_rdata_i[g];
    end
  end

  always_comb
  begin
    next_cur           = cur;
    // Strobes are single-cycle pulses
    next_cur.mem_we    = 1'b0;
    next_cur.stack_pop = 1'b0;
    next_cur.int_take  = 1'b0;

    if (gie_clear_i)
    begin
      next_cur.interrupt_control_register[GIE_BIT] = 1'b0;
    end

    if (exec_valid_i)
    begin
      if (pops_stack(op))
      begin
        next_cur.pc        = stack_top_i;
        next_cur.stack_pop = 1'b1;
      end
      else
      begin
        next_cur.pc = pc_inc;
      end

      if (updates_zero(op))
      begin
        next_cur.zero_flag = is_zero(or_result);
      end

      if (writes_mem(op))
      begin
        next_cur.mem_we    = 1'b1;
        next_cur.mem_waddr = mem_addr_i;
        if (op == OP_ROT_MEM)
        begin
          next_cur.mem_wdata = rot_byte;
        end
        else
        begin
          next_cur.mem_wdata = or_mem;
        end
      end

      unique case (op)
        OP_NONE:
        begin
          // Only the counter moves
        end
        OP_OR_IMM:
        begin
          next_cur.acc = or_imm;
        end
        OP_OR_MEM:
        begin
        end
        OP_SUB_EXIT:
        begin
          // Counter already loaded from the stack above
        end
        OP_SUB_EXIT_LIT:
        begin
          next_cur.acc = imm_i;
        end
        OP_INT_EXIT:
        begin
          // Set wins over a same-cycle clear so the re-enable is never lost
          next_cur.interrupt_control_register[GIE_BIT] = 1'b1;
          // Controller vectors before the popped address is fetched
          next_cur.int_take      = int_pending_i;
        end
        OP_ROT_MEM:
        begin
        end
        OP_ROT_ACC:
        begin
          next_cur.acc = rot_byte;
        end
      endcase
    end
  end

  // Synchronous reset clears every field
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cur.acc       <= ACC_RESET;
      cur.zero_flag <= 1'b0;
      cur.pc        <= PC_RESET;
      cur.interrupt_control_register      <= ZERO_BYTE;
      cur.mem_we    <= 1'b0;
      cur.mem_waddr <= '0;
      cur.mem_wdata <= ZERO_BYTE;
      cur.stack_pop <= 1'b0;
      cur.int_take  <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign acc_o                        = cur.acc;
  assign zero_flag_o                  = cur.zero_flag;
  assign pc_o                         = cur.pc;
  assign interrupt_control_register_o = cur.interrupt_control_register;
  assign mem_we_o                     = cur.mem_we;
  assign mem_waddr_o                  = cur.mem_waddr;
  assign mem_wdata_o                  = cur.mem_wdata;
  assign stack_pop_o                  = cur.stack_pop;
  assign int_take_o                   = cur.int_take;

endmodule : or_ret_rot_exec

// ### rtl/or_ret_rot_pkg.sv
// Purpose: Shared constants for the OR / return / rotate execution block
// Assumes: 8-bit data path, 12-bit program counter
// Notes:   Opcode codes are local to this block's command port
package or_ret_rot_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W   = 12;
  localparam int ADDR_W = 8;
  localparam int OP_W   = 3;

  typedef enum logic [OP_W-1:0] {
    OP_NONE        = 3'h0,
    OP_OR_IMM      = 3'h1,
    OP_OR_MEM      = 3'h2,
    OP_SUB_EXIT    = 3'h3,
    OP_SUB_EXIT_LIT = 3'h4,
    OP_INT_EXIT    = 3'h5,
    OP_ROT_MEM     = 3'h6,
    OP_ROT_ACC     = 3'h7
  } op_t;

  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET   = 12'h000;
  localparam int                GIE_BIT    = 0;
  localparam int                MSB_BIT    = DATA_W - 1;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [PC_W-1:0]   PC_STEP    = 12'h001;

endpackage : or_ret_rot_pkg

// ### testbench/cpu_or_return_rotate_exec_bench.sv
// Purpose: Self-checking bench for the OR / exit / rotate unit
// Assumes: One op per cycle, results one edge later
// Notes:   Rows run back to back through the registered accumulator
module cpu_or_return_rotate_exec_bench import or_ret_rot_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, rst_i = 1, exec_valid_i = 0, int_pending_i = 0, gie_clear_i = 0;
  logic [OP_W-1:0]   opcode_i = 0;
  logic [DATA_W-1:0] imm_i = 0, mem_rdata_i = 0, mem_addr_i = 8'h3c;
  logic [PC_W-1:0]   stack_top_i = 0, pc_o;
  logic [DATA_W-1:0] acc_o, interrupt_control_register_o, mem_wdata_o, mem_waddr_o;
  logic              zero_flag_o, mem_we_o, stack_pop_o, int_take_o;
  int                n_fail = 0, checks_done = 0, cyc = 0;
  // Row: op, imm, memory byte, expected acc, expected zero
  logic [31:0] rows [8] = '{32'h1000_0001, 32'h1810_0810, 32'h4000_0000, 32'h7008_1030,
                            32'h2000_0030, 32'h7000_0000, 32'h2000_0001, 32'h6008_0001};
  or_ret_rot_exec i_dut (.*);
  initial forever #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 200)
    begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 0;
    #1;
    chk(acc_o | pc_o | interrupt_control_register_o | zero_flag_o, 0);
    $display("reset test done");
    for (int i = 0; i <= 8; i++)
    begin
      @(posedge core_clk_i);
      exec_valid_i <= i < 8;
      {opcode_i, imm_i, mem_rdata_i} <= rows[i % 8][30:12];
      #1;
      if (i > 0) chk({zero_flag_o, acc_o}, {rows[i-1][0], rows[i-1][11:4]});
      if (i == 5) chk({mem_we_o, mem_waddr_o, mem_wdata_o}, {1'b1, 8'h3c, 8'h03});
      if (i == 6) chk(mem_we_o, 32'h0);
      if (i == 8) chk({mem_we_o, mem_waddr_o, mem_wdata_o}, {1'b1, 8'h3c, 8'h01});
      if (i == 8) chk(pc_o, 12'h005);
    end
    $display("row test done");
    // Interrupt exit with a request waiting, then a plain exit
    @(posedge core_clk_i);
    {exec_valid_i, opcode_i, stack_top_i, int_pending_i} <= {1'b1, 3'h5, 12'h5a5, 1'b1};
    @(posedge core_clk_i);
    {opcode_i, stack_top_i, int_pending_i, gie_clear_i} <= {3'h3, 12'h123, 1'b0, 1'b1};
    #1;
    chk({pc_o, interrupt_control_register_o}, {12'h5a5, 8'h01});
    chk(int_take_o, 1);
    @(posedge core_clk_i);
    {exec_valid_i, gie_clear_i} <= 2'h0;
    #1;
    chk({pc_o, stack_pop_o, int_take_o, zero_flag_o}, {12'h123, 3'h5});
    chk(interrupt_control_register_o, 8'h00);
    $display("exit test done");
    // Interrupt exit and an enable clear in the same cycle: the set wins
    @(posedge core_clk_i);
    {exec_valid_i, opcode_i, stack_top_i, gie_clear_i} <= {1'b1, 3'h5, 12'h077, 1'b1};
    @(posedge core_clk_i);
    {exec_valid_i, gie_clear_i} <= 2'h0;
    #1;
    chk({pc_o, interrupt_control_register_o, int_take_o}, {12'h077, 8'h01, 1'b0});
    $display("set wins test done");
    complete_run();
  end
endmodule : cpu_or_return_rotate_exec_bench

// ### testbench/ora_chk_asserts.sv
// Purpose: Assertions on the OR / exit / rotate unit ports
// Assumes: Results land one edge after a valid op
// Notes:   Bound to every instance of the unit
module ora_chk
  import or_ret_rot_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              exec_valid_i,
  input wire logic              int_pending_i,
  input wire logic              mem_we_o,
  input wire logic              zero_flag_o,
  input wire logic              stack_pop_o,
  input wire logic              int_take_o,
  input wire logic [OP_W-1:0]   opcode_i,
  input wire logic [DATA_W-1:0] imm_i,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic [DATA_W-1:0] acc_o,
  input wire logic [DATA_W-1:0] mem_wdata_o,
  input wire logic [DATA_W-1:0] interrupt_control_register_o,
  input wire logic [PC_W-1:0]   stack_top_i,
  input wire logic [PC_W-1:0]   pc_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire [DATA_W-1:0] rl = {mem_rdata_i[6:0], mem_rdata_i[7]};
  wire [OP_W-1:0]   op = exec_valid_i ? opcode_i : OP_NONE;
  or_imm_a:
    assert property (op==1 |=> acc_o==$past(acc_o|imm_i) && zero_flag_o==!acc_o) else $error("or imm");
  or_mem_a:
    assert property (op==2 |=> mem_we_o && mem_wdata_o==$past(acc_o|mem_rdata_i) && $stable(acc_o)
      && zero_flag_o==!mem_wdata_o) else $error("or mem");
  sub_exit_a:
    assert property (op==3 |=> stack_pop_o && pc_o==$past(stack_top_i) && $stable(zero_flag_o)) else $error("exit");
  lit_exit_a:
    assert property (op==4 |=> pc_o==$past(stack_top_i) && acc_o==$past(imm_i)) else $error("lit exit");
  int_exit_a:
    assert property (op==5 |=> interrupt_control_register_o[GIE_BIT] && pc_o==$past(stack_top_i)) else $error("iret");
  int_take_a:
    assert property (op==5 && int_pending_i |=> int_take_o) else $error("no service");
  rot_mem_a:
    assert property (op==6 |=> mem_we_o && mem_wdata_o==$past(rl) && $stable(zero_flag_o)) else $error("rot mem");
  rot_acc_a:
    assert property (op==7 |=> acc_o==$past(rl) && !mem_we_o && $stable(zero_flag_o)) else $error("rot acc");
  cover property (op==5 && int_pending_i);
  cover property (op==2 ##1 op==7);
  cover property (op==1 ##1 op==1);
endmodule : ora_chk
bind or_ret_rot_exec ora_chk u_chk (.*);
